// >>> ctm_pkg.sv
/*
 * constants, types and modes of the core test mode mux.
 * assumes a single core_clk domain and an apb register bus.
 */
// Summary of operation
// - isolate select low: core runs normally, all its normal pins valid.
// - isolate select high: test mode, inputs ignored, tri-states float, bidirs input.
// - test mode with bus strobe low: standby, test bus in ignored, out floats.
// - test mode with bus strobe high: core takes test inputs, drives test outputs.
// - buffers a,b: 00 normal, 01 low-drive, 10 quiescent, 11 forbidden.
// - low-drive test mode cuts output drive current to its minimum.
// - quiescent-current test mode disconnects every pull-up and pull-down.
// - mode buffers drive pad test controls through sync and decode flops, no extra control pins.
// - this block multiplexes external pins between normal and core test signals.
// - shared scheme: one dedicated test select plus two-bit shared test code.
// - shared select pins may be function pins, never test bus pins.
// - dedicated scheme: two-bit code of all four modes on dedicated pins.
// - shared test bus is 38 inputs and 42 outputs wide.
// - core test inputs come straight from pins, no flop, latch or inversion.
// - core test outputs reach pins straight, no flop, latch or inversion.
// - test bus pins may carry normal signals, chosen by decoded test mode, strobe pin and control share bit.
// - timing-critical pins should not be shared with test bus functions.
// - when sharing falls short, dedicated test pins are provided instead.
// - test bus strobe keeps its own external input pin.
// - target core gets strobe; every other core stays isolated in standby.
package ctm_pkg;
    localparam int TEST_IN_WIDTH   = 38;
    localparam int TEST_OUT_WIDTH  = 42;
    localparam int CORE_A_IN_WIDTH = 15;
    localparam int CORE_A_OUT_WIDTH = 35;
    localparam int CORE_B_IN_WIDTH = 38;
    localparam int CORE_B_OUT_WIDTH = 42;
    // register offsets, byte addresses
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    // control fields
    localparam int CTRL_SCHEME_BIT = 0;
    localparam int CTRL_SHARE_BIT  = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    // status fields
    localparam int STATUS_MODE_LSB  = 0;
    localparam int STATUS_FORBID_BIT = 8;
    localparam int STATUS_BUF_LSB   = 9;
    // shared scheme codes
    localparam logic [1:0] SHARED_CORE_A = 2'h0;
    localparam logic [1:0] SHARED_CORE_B = 2'h1;
    localparam logic [1:0] SHARED_USER   = 2'h2;
    // dedicated scheme codes
    localparam logic [1:0] DEDIC_NORMAL = 2'h0;
    localparam logic [1:0] DEDIC_CORE_A = 2'h1;
    localparam logic [1:0] DEDIC_CORE_B = 2'h2;
    localparam logic [1:0] DEDIC_USER   = 2'h3;
    typedef enum logic [5:0] {
        MODE_NORMAL     = 6'h01,
        MODE_CORE_A     = 6'h02,
        MODE_CORE_B     = 6'h04,
        MODE_USER       = 6'h08,
        MODE_LOW_DRIVE  = 6'h10,
        MODE_QUIESCENT  = 6'h20
    } ctm_mode_type;
endpackage

// >>> ctm_mode_if.sv
/*
 * decoded test mode passed from the decoder to the rest of the block.
 * assumes the decoder and its users share core_clk.
 */
`timescale 1ns/100ps
`default_nettype none
interface ctm_mode_if;
    ctm_pkg::ctm_mode_type mode;
    logic                  forbidden;
    logic [1:0]            buffers;
    logic                  scheme;
    modport decoder (output mode, output forbidden, output buffers, input scheme);
    modport user    (input mode, input forbidden, input buffers, output scheme);
endinterface
`default_nettype wire

// >>> ctm_mode_decode.sv
/*
 * synchronises the mode pins and decodes them into one mode.
 * assumes pins are asynchronous to core_clk and held steady during a test.
 */
`timescale 1ns/100ps
`default_nettype none
module ctm_mode_decode (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // mode pins: buffer a, buffer b, test select, code
    input  wire logic [4:0] mode_pins,
    // decoded mode
    ctm_mode_if.decoder     mode_bus
);
    logic [4:0] sync_1, sync_2, sync_3, stable;
    logic [4:0] next_stable;
    ctm_pkg::ctm_mode_type next_mode;

    always_comb begin
        next_stable = (sync_2 == sync_3) ? sync_3 : stable;
    end

    always_comb begin
        next_mode = ctm_pkg::MODE_NORMAL;
        if (stable[0]) begin
            next_mode = ctm_pkg::MODE_QUIESCENT;
        end else if (stable[1]) begin
            next_mode = ctm_pkg::MODE_LOW_DRIVE;
        end else if (mode_bus.scheme) begin
            case (stable[4:3])
                ctm_pkg::DEDIC_CORE_A: next_mode = ctm_pkg::MODE_CORE_A;
                ctm_pkg::DEDIC_CORE_B: next_mode = ctm_pkg::MODE_CORE_B;
                ctm_pkg::DEDIC_USER:   next_mode = ctm_pkg::MODE_USER;
                default:               next_mode = ctm_pkg::MODE_NORMAL;
            endcase
        end else if (stable[2]) begin
            case (stable[4:3])
                ctm_pkg::SHARED_CORE_A: next_mode = ctm_pkg::MODE_CORE_A;
                ctm_pkg::SHARED_CORE_B: next_mode = ctm_pkg::MODE_CORE_B;
                default:                next_mode = ctm_pkg::MODE_USER;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_1        <= 5'h00;
            sync_2        <= 5'h00;
            sync_3        <= 5'h00;
            stable        <= 5'h00;
            mode_bus.mode <= ctm_pkg::MODE_NORMAL;
        end else begin
            sync_1        <= mode_pins;
            sync_2        <= sync_1;
            sync_3        <= sync_2;
            stable        <= next_stable;
            mode_bus.mode <= next_mode;
        end
    end

    assign mode_bus.forbidden = stable[0] & stable[1];
    assign mode_bus.buffers   = stable[1:0];
endmodule // ctm_mode_decode
`default_nettype wire

// >>> ctm_test_steer.sv
/*
 * combinational steering of core test outputs onto the shared output pins.
 * assumes selects are core_clk flops gated by the strobe pin; data paths carry no storage.
 */
`timescale 1ns/100ps
`default_nettype none
module ctm_test_steer (
    // selection
    input  wire logic                              sel_a,
    input  wire logic                              sel_b,
    input  wire logic                              share_en,
    // sources
    input  wire logic [ctm_pkg::TEST_OUT_WIDTH-1:0] a_out,
    input  wire logic [ctm_pkg::TEST_OUT_WIDTH-1:0] a_en,
    input  wire logic [ctm_pkg::TEST_OUT_WIDTH-1:0] b_out,
    input  wire logic [ctm_pkg::TEST_OUT_WIDTH-1:0] b_en,
    input  wire logic [ctm_pkg::TEST_OUT_WIDTH-1:0] func_out,
    input  wire logic [ctm_pkg::TEST_OUT_WIDTH-1:0] func_oe,
    // pins
    output logic [ctm_pkg::TEST_OUT_WIDTH-1:0]      pin_out,
    output logic [ctm_pkg::TEST_OUT_WIDTH-1:0]      pin_oe
);
    genvar i;
    generate
        for (i = 0; i < ctm_pkg::TEST_OUT_WIDTH; i++) begin : g_bit
            // no flop or inversion between core and pin
            assign pin_out[i] = sel_a ? a_out[i] : sel_b ? b_out[i] : (share_en & func_out[i]);
            assign pin_oe[i]  = sel_a ? a_en[i] : sel_b ? b_en[i] : (share_en & func_oe[i]);
        end
    endgenerate
endmodule // ctm_test_steer
`default_nettype wire

// >>> core_test_mode_mux.sv
/*
 * test access for two embedded cores and user logic: mode decode,
 * isolation and strobe control, pin sharing, pad test controls, apb regs.
 * assumes an apb master on core_clk and a tester on the pins; test data
 * paths are combinational so that the tester reaches the cores directly.
 */
`timescale 1ns/100ps
`default_nettype none
module core_test_mode_mux (
    // clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               reset_n,
    // apb slave
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [7:0]                         paddr,
    input  wire logic [31:0]                        pwdata,
    output logic [31:0]                             prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    // mode pins
    input  wire logic                               mode_set_buffer_a,
    input  wire logic                               mode_set_buffer_b,
    input  wire logic                               test_select_pin,
    input  wire logic [1:0]                         test_code_pin,
    input  wire logic                               test_bus_strobe_pin,
    // pad test controls
    output logic                                    low_drive_test_mode,
    output logic                                    quiescent_current_test_mode,
    // shared test bus pins
    input  wire logic [ctm_pkg::TEST_IN_WIDTH-1:0]  test_signal_in_pin,
    output logic [ctm_pkg::TEST_OUT_WIDTH-1:0]      test_signal_out_pin,
    output logic [ctm_pkg::TEST_OUT_WIDTH-1:0]      test_signal_out_oe,
    // user logic side
    output logic [ctm_pkg::TEST_IN_WIDTH-1:0]       user_func_in,
    input  wire logic [ctm_pkg::TEST_OUT_WIDTH-1:0] user_func_out,
    input  wire logic [ctm_pkg::TEST_OUT_WIDTH-1:0] user_func_oe,
    output logic                                    user_test_active,
    // core a
    output logic                                    core_a_isolate_select,
    output logic                                    core_a_test_bus_strobe,
    output logic [ctm_pkg::CORE_A_IN_WIDTH-1:0]     core_a_test_in_bus,
    input  wire logic [ctm_pkg::CORE_A_OUT_WIDTH-1:0] core_a_test_out_bus,
    input  wire logic [ctm_pkg::CORE_A_OUT_WIDTH-1:0] core_a_test_out_en,
    // core b
    output logic                                    core_b_isolate_select,
    output logic                                    core_b_test_bus_strobe,
    output logic [ctm_pkg::CORE_B_IN_WIDTH-1:0]     core_b_test_in_bus,
    input  wire logic [ctm_pkg::CORE_B_OUT_WIDTH-1:0] core_b_test_out_bus,
    input  wire logic [ctm_pkg::CORE_B_OUT_WIDTH-1:0] core_b_test_out_en
);
    localparam int PAD_A = ctm_pkg::TEST_OUT_WIDTH - ctm_pkg::CORE_A_OUT_WIDTH;

    ctm_mode_if mode_bus ();

    logic [1:0]  ctrl;
    logic [1:0]  next_ctrl;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        setup_phase;
    logic        access_done;
    logic        addr_ctrl;
    logic        addr_status;

    logic        target_a;
    logic        target_b;
    logic        next_iso_a;
    logic        next_iso_b;
    logic        next_target_a;
    logic        next_target_b;
    logic        next_user;
    logic        next_low_drive;
    logic        next_quiescent;
    logic [ctm_pkg::TEST_OUT_WIDTH-1:0] a_out_wide;
    logic [ctm_pkg::TEST_OUT_WIDTH-1:0] a_en_wide;

    // mode pins decoded after three-stage synchronisation
    ctm_mode_decode u_decode (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .mode_pins ({test_code_pin, test_select_pin, mode_set_buffer_b, mode_set_buffer_a}),
        .mode_bus  (mode_bus.decoder)
    );

    assign mode_bus.scheme = ctrl[ctm_pkg::CTRL_SCHEME_BIT];

    // ---------------- apb slave ----------------
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign addr_ctrl   = (paddr == ctm_pkg::CTRL_OFFSET);
    assign addr_status = (paddr == ctm_pkg::STATUS_OFFSET);

    always_comb begin
        next_pready  = setup_phase;
        next_pslverr = setup_phase & ~addr_ctrl & ~addr_status;
        next_prdata  = 32'h0000_0000;
        if (setup_phase & ~pwrite & addr_ctrl) begin
            next_prdata[1:0] = ctrl;
        end else if (setup_phase & ~pwrite & addr_status) begin
            next_prdata[ctm_pkg::STATUS_MODE_LSB +: 6] = mode_bus.mode;
            next_prdata[ctm_pkg::STATUS_FORBID_BIT]    = mode_bus.forbidden;
            next_prdata[ctm_pkg::STATUS_BUF_LSB +: 2]  = mode_bus.buffers;
        end
    end

    always_comb begin
        next_ctrl = ctrl;
        if (access_done & pwrite & addr_ctrl) begin
            next_ctrl = pwdata[1:0];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            ctrl    <= ctm_pkg::CTRL_RESET;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
            ctrl    <= next_ctrl;
        end
    end

    // ---------------- core isolation and targets ----------------
    always_comb begin
        next_iso_a     = 1'b0;
        next_iso_b     = 1'b0;
        next_target_a  = 1'b0;
        next_target_b  = 1'b0;
        next_user      = 1'b0;
        next_low_drive = 1'b0;
        next_quiescent = 1'b0;
        case (mode_bus.mode)
            ctm_pkg::MODE_NORMAL: begin
                next_iso_a = 1'b0;
            end
            ctm_pkg::MODE_CORE_A: begin
                next_iso_a    = 1'b1;
                next_iso_b    = 1'b1;
                next_target_a = 1'b1;
            end
            ctm_pkg::MODE_CORE_B: begin
                next_iso_a    = 1'b1;
                next_iso_b    = 1'b1;
                next_target_b = 1'b1;
            end
            ctm_pkg::MODE_USER: begin
                next_iso_a = 1'b1;
                next_iso_b = 1'b1;
                next_user  = 1'b1;
            end
            ctm_pkg::MODE_LOW_DRIVE: begin
                next_low_drive = 1'b1;
            end
            ctm_pkg::MODE_QUIESCENT: begin
                next_quiescent = 1'b1;
            end
            default: begin
                next_iso_a = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_a_isolate_select       <= 1'b0;
            core_b_isolate_select       <= 1'b0;
            target_a                    <= 1'b0;
            target_b                    <= 1'b0;
            user_test_active            <= 1'b0;
            low_drive_test_mode         <= 1'b0;
            quiescent_current_test_mode <= 1'b0;
        end else begin
            core_a_isolate_select       <= next_iso_a;
            core_b_isolate_select       <= next_iso_b;
            target_a                    <= next_target_a;
            target_b                    <= next_target_b;
            user_test_active            <= next_user;
            low_drive_test_mode         <= next_low_drive;
            quiescent_current_test_mode <= next_quiescent;
        end
    end

    // ---------------- test input steering ----------------
    // strobe has its own pin and passes without flops
    assign core_a_test_bus_strobe = target_a & test_bus_strobe_pin;
    assign core_b_test_bus_strobe = target_b & test_bus_strobe_pin;
    // standby or normal cores see a quiet test bus
    assign core_a_test_in_bus = test_signal_in_pin[ctm_pkg::CORE_A_IN_WIDTH-1:0]
                              & {ctm_pkg::CORE_A_IN_WIDTH{core_a_test_bus_strobe}};
    assign core_b_test_in_bus = test_signal_in_pin[ctm_pkg::CORE_B_IN_WIDTH-1:0]
                              & {ctm_pkg::CORE_B_IN_WIDTH{core_b_test_bus_strobe}};
    // user logic keeps its pins in every mode except core a or core b test
    assign user_func_in = test_signal_in_pin
                        & {ctm_pkg::TEST_IN_WIDTH{~(target_a | target_b)}};

    // ---------------- test output steering ----------------
    assign a_out_wide = {{PAD_A{1'b0}}, core_a_test_out_bus};
    assign a_en_wide  = {{PAD_A{1'b0}}, core_a_test_out_en};

    // critical-path pins belong outside this shared bus: the selector adds delay
    ctm_test_steer u_steer (
        .sel_a    (core_a_test_bus_strobe),
        .sel_b    (core_b_test_bus_strobe),
        .share_en (ctrl[ctm_pkg::CTRL_SHARE_BIT] | user_test_active),
        .a_out    (a_out_wide),
        .a_en     (a_en_wide),
        .b_out    (core_b_test_out_bus),
        .b_en     (core_b_test_out_en),
        .func_out (user_func_out),
        .func_oe  (user_func_oe),
        .pin_out  (test_signal_out_pin),
        .pin_oe   (test_signal_out_oe)
    );

    // ---------------- checks ----------------
    sequence seq_pins_core_a;
        !mode_set_buffer_a && !mode_set_buffer_b && test_select_pin
        && !ctrl[ctm_pkg::CTRL_SCHEME_BIT] && test_code_pin == ctm_pkg::SHARED_CORE_A;
    endsequence

    sequence seq_core_a_settled;
        core_a_isolate_select && core_b_isolate_select && target_a && !target_b;
    endsequence

    property prop_core_a_select;
        @(posedge core_clk) disable iff (!reset_n)
        seq_pins_core_a [*8] |-> ##[0:2] seq_core_a_settled;
    endproperty

    AST_CORE_A_SELECT: assert property (prop_core_a_select)
        else $error("core a not selected after shared code held");

    AST_ONE_TARGET: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(target_a && target_b))
        else $error("two cores targeted at once");

    AST_ISO_WITH_TARGET: assert property (@(posedge core_clk) disable iff (!reset_n)
        (target_a || target_b || user_test_active) |-> (core_a_isolate_select && core_b_isolate_select))
        else $error("targeted mode without isolation of all cores");

    AST_STANDBY_FLOATS: assert property (@(posedge core_clk) disable iff (!reset_n)
        (core_b_isolate_select && !core_b_test_bus_strobe) |-> core_b_test_in_bus == '0)
        else $error("standby core sees test inputs");

    AST_NORMAL_NO_STROBE: assert property (@(posedge core_clk) disable iff (!reset_n)
        !core_a_isolate_select |-> (!core_a_test_bus_strobe && core_a_test_in_bus == '0))
        else $error("normal mode core receives test bus");

    AST_PASS_THROUGH: assert property (@(posedge core_clk) disable iff (!reset_n)
        core_b_test_bus_strobe |-> (test_signal_out_pin == core_b_test_out_bus
        && core_b_test_in_bus == test_signal_in_pin))
        else $error("core b test path not direct");

    AST_LOW_DRIVE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!mode_set_buffer_a && mode_set_buffer_b) [*6] |-> ##[0:1] low_drive_test_mode)
        else $error("low drive mode not entered");

    AST_QUIESCENT: assert property (@(posedge core_clk) disable iff (!reset_n)
        (mode_set_buffer_a && !mode_set_buffer_b) [*6] |-> ##[0:1]
        (quiescent_current_test_mode && !low_drive_test_mode && !core_a_isolate_select))
        else $error("quiescent mode not entered");

    AST_DEDICATED_USER: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!mode_set_buffer_a && !mode_set_buffer_b && ctrl[ctm_pkg::CTRL_SCHEME_BIT]
        && test_code_pin == ctm_pkg::DEDIC_USER) [*8] |-> ##[0:2] user_test_active)
        else $error("dedicated code did not select user test");

    AST_PADS_EXCLUSIVE: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(low_drive_test_mode && quiescent_current_test_mode))
        else $error("both pad test modes active");

    AST_APB_ONE_WAIT: assert property (@(posedge core_clk) disable iff (!reset_n)
        (psel && !penable) ##1 (psel && penable) |-> pready)
        else $error("apb access not answered in first access cycle");

endmodule // core_test_mode_mux
`default_nettype wire

// >>> ctm_tester_model.sv
/*
 * production tester model that drives the mode, strobe and test input pins.
 * assumes commands change just after a rising core_clk edge.
 */
`timescale 1ns/100ps
`default_nettype none
module ctm_tester_model (
    // clock and commands
    input  wire logic                              core_clk,
    input  wire logic [1:0]                        want_buffers,
    input  wire logic                              want_select,
    input  wire logic [1:0]                        want_code,
    input  wire logic                              want_strobe,
    input  wire logic [ctm_pkg::TEST_IN_WIDTH-1:0] want_data,
    // chip pins
    output logic                                   mode_set_buffer_a,
    output logic                                   mode_set_buffer_b,
    output logic                                   test_select_pin,
    output logic [1:0]                             test_code_pin,
    output logic                                   test_bus_strobe_pin,
    output logic [ctm_pkg::TEST_IN_WIDTH-1:0]      test_signal_in_pin
);
    initial begin
        {mode_set_buffer_a, mode_set_buffer_b, test_select_pin, test_code_pin, test_bus_strobe_pin} = '0;
        test_signal_in_pin = '0;
    end
    always @(posedge core_clk) begin
        // both buffers high is never put on the pins
        mode_set_buffer_a   <= want_buffers[0] & ~want_buffers[1];
        mode_set_buffer_b   <= want_buffers[1];
        test_select_pin     <= want_select;
        test_code_pin       <= want_code;
        test_bus_strobe_pin <= want_strobe;
        test_signal_in_pin  <= want_data;
    end
endmodule // ctm_tester_model
`default_nettype wire

// >>> core_test_mode_mux_test.sv
/*
 * self-checking bench: apb registers, mode decode, steering of test paths.
 * assumes the tester model on the pins and random core and user outputs.
 */
`timescale 1ns/100ps
`default_nettype none
module core_test_mode_mux_test;
    logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, ma, mb, sp, stb, ld, qc, uta, ia, sa, ib, sb, w_sel = 0, w_stb = 0;
    logic [1:0] cp, w_buf = '0, w_code = '0;
    logic [37:0] din, w_data = '0, ufi, cbi;
    logic [41:0] po, poe, uo = '0, uoe = '0, bo = '0, boe = '0;
    logic [14:0] cai;
    logic [34:0] ao = '0, aoe = '0;
    logic [3:0] e;
    int errors = 0, checked = 0, cycles = 0;
    initial forever #12.5 core_clk = ~core_clk;
    ctm_tester_model u_ctm_tester_model (.core_clk(core_clk), .want_buffers(w_buf), .want_select(w_sel),
        .want_code(w_code), .want_strobe(w_stb), .want_data(w_data), .mode_set_buffer_a(ma),
        .mode_set_buffer_b(mb), .test_select_pin(sp), .test_code_pin(cp), .test_bus_strobe_pin(stb),
        .test_signal_in_pin(din));
    core_test_mode_mux u_core_test_mode_mux (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_set_buffer_a(ma), .mode_set_buffer_b(mb),
        .test_select_pin(sp), .test_code_pin(cp), .test_bus_strobe_pin(stb), .low_drive_test_mode(ld),
        .quiescent_current_test_mode(qc), .test_signal_in_pin(din), .test_signal_out_pin(po),
        .test_signal_out_oe(poe), .user_func_in(ufi), .user_func_out(uo), .user_func_oe(uoe),
        .user_test_active(uta), .core_a_isolate_select(ia), .core_a_test_bus_strobe(sa),
        .core_a_test_in_bus(cai), .core_a_test_out_bus(ao), .core_a_test_out_en(aoe),
        .core_b_isolate_select(ib), .core_b_test_bus_strobe(sb), .core_b_test_in_bus(cbi),
        .core_b_test_out_bus(bo), .core_b_test_out_en(boe));
    task automatic wrap_up;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // {user, b, a, test} for a control value, select pin and code
    function automatic logic [3:0] exp_tgt(input logic [1:0] c, input logic s, input logic [1:0] k);
        if (c[0])
            return (k == 2'h0) ? 4'h0 : (k == 2'h1) ? 4'h3 : (k == 2'h2) ? 4'h5 : 4'h9;
        if (!s)
            return 4'h0;
        return (k == 2'h0) ? 4'h3 : (k == 2'h1) ? 4'h5 : 4'h9;
    endfunction
    task automatic mode_test(input logic [1:0] c, input logic s, input logic [1:0] k);
        apb(1, ctm_pkg::CTRL_OFFSET, {30'h0, c});
        w_sel <= s; w_code <= k; w_stb <= 1;
        repeat (10) @(posedge core_clk);
        e = exp_tgt(c, s, k);
        w_data <= {$urandom, $urandom}; ao <= {$urandom, $urandom}; bo <= {$urandom, $urandom};
        uo <= {$urandom, $urandom}; aoe <= 35'({$urandom, $urandom}); boe <= '1; uoe <= '1;
        repeat (2) @(negedge core_clk);
        chk({ia, ib, uta}, {e[0], e[0], e[3]});
        chk({sa, sb}, {e[1], e[2]});
        chk(cai, e[1] ? din[14:0] : 15'h0);
        chk(cbi, e[2] ? din : 38'h0);
        chk(ufi, (e[1] | e[2]) ? 38'h0 : din);
        if (e[1]) chk(po[34:0], ao);
        if (e[1]) chk(poe, {7'h0, aoe});
        if (e[2]) chk(po, bo);
        if (!e[1] && !e[2] && (c[1] || e[3])) chk(po, uo);
        if (!e[1] && !e[2] && !c[1] && !e[3]) chk(poe, 42'h0);
        @(posedge core_clk);
        w_stb <= 0;
        repeat (2) @(negedge core_clk);
        chk({sa, sb, cai, cbi}, 55'h0);
        apb(0, ctm_pkg::STATUS_OFFSET, 32'h0);
        chk(rd[5:0], e[0] ? {2'h0, e[3:1], 1'b0} : 6'h01);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'hf14f441d));
        repeat (12) @(posedge core_clk);
        reset_n <= 1;
        apb(0, ctm_pkg::CTRL_OFFSET, 32'h0);
        chk(rd, 32'h2);
        apb(0, 8'h08, 32'h0);
        chk({er, rd}, 33'h100000000);
        for (int i = 0; i < 16; i++)
            mode_test(i[3] ? {i[2], 1'b1} : {1'b1 ^ i[2] & i[1], 1'b0}, i[2], i[1:0]);
        for (int i = 1; i < 4; i++) begin
            w_buf <= i[1:0];
            repeat (10) @(posedge core_clk);
            chk({ld, qc, ia, ib}, {i[1], ~i[1], 2'b00});
            apb(0, ctm_pkg::STATUS_OFFSET, 32'h0);
            chk({rd[10:8], rd[5:0]}, i[1] ? 9'h110 : 9'h0a0);
        end
        w_buf <= 2'h0;
        repeat (10) @(posedge core_clk);
        chk({ld, qc}, 2'h0);
        wrap_up();
    end
endmodule // core_test_mode_mux_test
`default_nettype wire
